// >>> dv/plq_host.sv
// Remote host model: one-cycle register writes and reads.
// Assumes rdata valid in the cycle after the read strobe.
`timescale 1ns/1ns
`include "plq_defines.vh"
module plq_host (
	// Clock
	input wire        clk,
	// Register port
	output reg [3:0]  addr,
	output reg [15:0] wdata,
	output reg        wr,
	output reg        rd,
	input wire [15:0] rdata
);
initial
begin
	addr = 4'h0;
	wdata = 16'h0000;
	wr = 1'b0;
	rd = 1'b0;
end
task put(input [3:0] a, input [15:0] v);
begin
	@(posedge clk);
	addr <= a;
	wdata <= v;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
	// Stale data must not look valid
	wdata <= ~v;
end
endtask
task get(input [3:0] a, output [15:0] v);
begin
	@(posedge clk);
	addr <= a;
	rd <= 1'b1;
	@(posedge clk);
	rd <= 1'b0;
	#1 v = rdata;
end
endtask
// No local path for these settings
task prog_iprot(input [15:0] dly);
begin
	put(`PLQ_ADDR_IPROT_CTRL, 16'h0001);
	put(`PLQ_ADDR_IPROT_DELAY, dly);
end
endtask
endmodule

// >>> dv/plq_top_bench.sv
// Self-checking bench for plq_top.
// Host model drives the bus; bench drives conditions and panel.
`timescale 1ns/1ns
`include "plq_defines.vh"
module plq_top_bench;
reg         clk = 1'b0;
reg         resetn = 1'b0;
reg  [4:0]  cond = 5'h00;
reg         kclr = 1'b0;
reg         ktog = 1'b0;
reg         sdone = 1'b0;
reg  [5:0]  sfail = 6'h00;
wire [3:0]  addr;
wire [15:0] wdata;
wire        wr;
wire        rd;
wire [15:0] rdata;
wire        on, buz, plim, erri, lat, cti, lrcc, sev;
integer     n_fail = 0;
integer     num_checks = 0;
integer     cyc = 0;
integer     i, f;
reg  [15:0] d;
reg  [15:0] stc [0:5];
reg  [15:0] msk [0:4];
plq_host host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata));
plq_top #(.TICK_DIV(10), .PWR_MS(5)) dut (.clk(clk), .resetn(resetn),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.over_voltage(cond[0]), .over_current(cond[1]), .over_power(cond[2]),
	.over_temp(cond[3]), .reversed(cond[4]), .key_clear(kclr),
	.key_input_toggle(ktog), .selftest_done(sdone), .selftest_fail(sfail),
	.input_on(on), .buzzer(buz), .power_limit(plim), .err_indicator(erri),
	.latched(lat), .current_timing_indicator(cti),
	.low_range_constant_current_mode(lrcc), .status_event(sev));
always #5 clk = ~clk;
// Hang guard
always @(posedge clk)
begin
	cyc <= cyc + 1;
	if (cyc == 20000)
	begin
		n_fail = n_fail + 1;
		results;
	end
end
function [15:0] ecode(input integer k);
	integer n;
	begin
		n = 100 * (k % 4 + 1) + k;
		ecode = 16'h0000 - n[15:0];
	end
endfunction
task chk(input [15:0] got, input [15:0] exp);
begin
	num_checks = num_checks + 1;
	if (got !== exp)
	begin
		n_fail = n_fail + 1;
		$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
	end
end
endtask
task rdc(input [3:0] a, input [15:0] exp);
begin
	host.get(a, d);
	chk(d, exp);
end
endtask
task results;
begin
	$display("checks %0d fails %0d", num_checks, n_fail);
	if (n_fail == 0 && num_checks > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end
endtask
initial
begin
	stc[0] = `PLQ_ST_DISPLAY; stc[1] = `PLQ_ST_ADC; stc[2] = `PLQ_ST_NOISY;
	stc[3] = `PLQ_ST_KEYPAD; stc[4] = `PLQ_ST_CHECKSUM; stc[5] = `PLQ_ST_TEMP;
	msk[0] = 16'h0021; msk[1] = 16'h0042; msk[2] = 16'h0044;
	msk[3] = 16'h0048; msk[4] = 16'h0030;
	repeat (4) @(posedge clk);
	resetn <= 1'b1;
	@(posedge clk);
	#1 chk({lat, on, erri}, 16'h0000);
	$display("test reset done");
	for (i = 0; i < 6; i = i + 1)
	begin
		@(posedge clk);
		sfail <= 6'h01 << i;
		sdone <= 1'b1;
		@(posedge clk);
		sdone <= 1'b0;
		rdc(`PLQ_ADDR_SELFTEST, stc[i]);
	end
	chk(lrcc, 16'h0000);
	@(posedge clk);
	sfail <= 6'h00;
	sdone <= 1'b1;
	@(posedge clk);
	sdone <= 1'b0;
	#1 chk({lrcc, on}, 16'h0002);
	rdc(`PLQ_ADDR_IPROT_DELAY, `PLQ_RST_IPROT_DELAY);
	host.put(`PLQ_ADDR_IPROT_LEVEL, 16'h1234);
	rdc(`PLQ_ADDR_IPROT_LEVEL, 16'h1234);
	// Input key works while not latched
	@(posedge clk);
	ktog <= 1'b1;
	@(posedge clk);
	ktog <= 1'b0;
	#1 chk(on, 16'h0001);
	@(posedge clk);
	ktog <= 1'b1;
	@(posedge clk);
	ktog <= 1'b0;
	#1 chk(on, 16'h0000);
	$display("test selftest done");
	// Two pushes past capacity; class seen after each early push
	for (i = 0; i < 22; i = i + 1)
	begin
		host.put(`PLQ_ADDR_ERR_PUSH, ecode(i));
		if (i < 4)
			rdc(`PLQ_ADDR_COUNT, {9'h000, i[1:0], i[4:0] + 5'h01});
	end
	host.get(`PLQ_ADDR_COUNT, d);
	chk(d & 16'h001F, 16'h0014);
	chk(erri, 16'h0001);
	for (i = 0; i < 19; i = i + 1)
		rdc(`PLQ_ADDR_ERRQ, ecode(i));
	rdc(`PLQ_ADDR_ERRQ, `PLQ_ERR_TOO_MANY);
	rdc(`PLQ_ADDR_ERRQ, `PLQ_ERR_NONE);
	chk(erri, 16'h0000);
	$display("test queue done");
	// Order: voltage, current, power, temperature, polarity
	for (f = 0; f < 5; f = f + 1)
	begin
		host.put(`PLQ_ADDR_ENABLE, (f == 0) ? 16'h0000 : 16'hFFFF);
		host.prog_iprot(16'h0003);
		host.put(`PLQ_ADDR_CMD, `PLQ_CMD_INPUT_ON);
		@(posedge clk);
		cond <= 5'h01 << f;
		repeat (5) @(posedge clk);
		#1 if (f == 1) chk({cti, on}, 16'h0003);
		repeat (80) @(posedge clk);
		#1 chk({lat, on, buz}, 16'h0005);
		chk(sev, (f == 0) ? 16'h0000 : 16'h0001);
		if (f == 2) chk(plim, 16'h0001);
		host.get(`PLQ_ADDR_STATUS, d);
		chk(d & msk[f], msk[f]);
		host.put(`PLQ_ADDR_CMD, `PLQ_CMD_CLEAR);
		host.put(`PLQ_ADDR_CMD, `PLQ_CMD_INPUT_ON);
		// Settings and input key refused while latched
		host.put(`PLQ_ADDR_IPROT_DELAY, 16'h0007);
		rdc(`PLQ_ADDR_IPROT_DELAY, 16'h0003);
		@(posedge clk);
		ktog <= 1'b1;
		@(posedge clk);
		ktog <= 1'b0;
		@(posedge clk);
		#1 chk({lat, on}, 16'h0002);
		@(posedge clk);
		cond <= 5'h00;
		@(posedge clk);
		kclr <= 1'b1;
		@(posedge clk);
		kclr <= 1'b0;
		@(posedge clk);
		#1 chk(lat, 16'h0000);
		host.get(`PLQ_ADDR_EVENT, d);
		chk(d & msk[f], msk[f]);
		chk(sev, 16'h0000);
	end
	$display("test faults done");
	results;
end
endmodule

// >>> dv/plq_top_sva.sv
// Port assertions for the protection latch and error queue.
// Bound into plq_top; sees only its ports.
`timescale 1ns/1ns
`include "plq_defines.vh"
module plq_sva (
	// Clock, reset, bus
	input wire        clk,
	input wire        resetn,
	input wire [3:0]  addr,
	input wire [15:0] wdata,
	input wire        wr,
	// Conditions and panel
	input wire        over_voltage,
	input wire        over_power,
	input wire        over_temp,
	input wire        reversed,
	input wire        key_clear,
	input wire        selftest_done,
	input wire [5:0]  selftest_fail,
	// Outputs
	input wire        input_on,
	input wire        buzzer,
	input wire        power_limit,
	input wire        err_indicator,
	input wire        latched,
	input wire        current_timing_indicator,
	input wire        low_range_constant_current_mode,
	input wire        status_event
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
wire clr = key_clear |
	(wr & addr == `PLQ_ADDR_CMD & wdata[7:0] == `PLQ_CMD_CLEAR);
sequence fault_seen;
	over_voltage || over_temp || reversed;
endsequence
sequence st_pass;
	selftest_done && selftest_fail == 6'h00;
endsequence
chk_fault_latch: assert property (fault_seen |=> latched && buzzer && !input_on)
	else $error("fault did not latch");
chk_latch_off: assert property (latched |-> !input_on)
	else $error("input on while latched");
chk_latch_hold: assert property (latched && !clr |=> latched)
	else $error("latch left without clear");
chk_hot_relatch: assert property (latched && clr && over_temp |=> latched)
	else $error("clear succeeded while hot");
chk_limit_now: assert property (power_limit == over_power)
	else $error("power limit not immediate");
chk_err_quiet: assert property (!err_indicator && !wr |=> !err_indicator)
	else $error("error lamp without error");
chk_timing_free: assert property (current_timing_indicator |-> !latched)
	else $error("timing lamp while latched");
chk_mode_pass: assert property (st_pass |=> low_range_constant_current_mode)
	else $error("mode not set after self-test");
chk_event_idle: assert property ($rose(resetn) |-> !status_event)
	else $error("event right after reset");
endmodule
bind plq_top plq_sva chk (.clk(clk), .resetn(resetn), .addr(addr),
	.wdata(wdata), .wr(wr), .over_voltage(over_voltage),
	.over_power(over_power), .over_temp(over_temp), .reversed(reversed),
	.key_clear(key_clear), .selftest_done(selftest_done),
	.selftest_fail(selftest_fail), .input_on(input_on), .buzzer(buzzer),
	.power_limit(power_limit), .err_indicator(err_indicator),
	.latched(latched), .current_timing_indicator(current_timing_indicator),
	.low_range_constant_current_mode(low_range_constant_current_mode),
	.status_event(status_event));

// >>> rtl/plq_defines.vh
// Constants for the protection latch and error queue block.
// Included by plq_top.v; definitions only.
`ifndef PLQ_DEFINES_VH
`define PLQ_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PLQ_ADDR_ERRQ      4'h0
`define PLQ_ADDR_COUNT     4'h1
`define PLQ_ADDR_STATUS    4'h2
`define PLQ_ADDR_ENABLE    4'h3
`define PLQ_ADDR_EVENT     4'h4
`define PLQ_ADDR_IPROT_CTRL  4'h5
`define PLQ_ADDR_IPROT_LEVEL 4'h6
`define PLQ_ADDR_IPROT_DELAY 4'h7
`define PLQ_ADDR_CMD       4'h8
`define PLQ_ADDR_ERR_PUSH  4'h9
`define PLQ_ADDR_SELFTEST  4'hA

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define PLQ_BIT_EXVOLT  0
`define PLQ_BIT_EXCURR  1
`define PLQ_BIT_EXPOWR  2
`define PLQ_BIT_THERML  3
`define PLQ_BIT_REVPOL  4
`define PLQ_BIT_VSUMRY  5
`define PLQ_BIT_PSUMRY  6
`define PLQ_BIT_CTIMER  7
`define PLQ_BIT_LAT     8
`define PLQ_BIT_ERR     9

// ----------------------------------------
// Error codes and class ranges
// ----------------------------------------
`define PLQ_ERR_TOO_MANY  16'hFEA2
`define PLQ_ERR_NONE      16'h0000
`define PLQ_ST_DISPLAY    16'h0259
`define PLQ_ST_ADC        16'h025B
`define PLQ_ST_NOISY      16'h025F
`define PLQ_ST_KEYPAD     16'h0260
`define PLQ_ST_CHECKSUM   16'h0261
`define PLQ_ST_TEMP       16'h0276
`define PLQ_CLASS_CMD     2'h0
`define PLQ_CLASS_EXEC    2'h1
`define PLQ_CLASS_DEV     2'h2
`define PLQ_CLASS_QUERY   2'h3

// ----------------------------------------
// Reset values, timing and command codes
// ----------------------------------------
`define PLQ_RST_IPROT_DELAY 16'hEA60
`define PLQ_RST_IPROT_LEVEL 16'h0000
`define PLQ_CLK_HZ        100000000
`define PLQ_TICK_US       1000
`define PLQ_PWR_LIMIT_MS  10000
`define PLQ_CMD_CLEAR     8'h01
`define PLQ_CMD_INPUT_ON  8'h02
`define PLQ_CMD_INPUT_OFF 8'h03

`endif

// >>> rtl/plq_top.v
// Protection latch, fault timers and remote error queue of a load.
// Assumes synchronous comparator inputs and a plain register port
// driven by the controller that parses remote commands.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
`include "plq_defines.vh"

module plq_top #(
	parameter DEPTH     = 20,
	parameter TICK_DIV  = (`PLQ_CLK_HZ / 1000000) * `PLQ_TICK_US,
	parameter PWR_MS    = `PLQ_PWR_LIMIT_MS
) (
	// Clock and reset
	input  wire        clk,
	input  wire        resetn,
	// Register port
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata,
	// Comparators from the analog side
	input  wire        over_voltage,
	input  wire        over_current,
	input  wire        over_power,
	input  wire        over_temp,
	input  wire        reversed,
	// Front panel and self-test
	input  wire        key_clear,
	input  wire        key_input_toggle,
	input  wire        selftest_done,
	input  wire [5:0]  selftest_fail,
	// Indicators and actuators
	output reg         input_on,
	output reg         buzzer,
	output wire        power_limit,
	output wire        err_indicator,
	output reg         latched,
	output wire        current_timing_indicator,
	output reg         low_range_constant_current_mode,
	output wire        status_event
);

	// Sized copies; depth limited to 31 by the 5-bit count
	localparam [4:0]  Q_DEPTH   = DEPTH[4:0];
	localparam [4:0]  Q_LAST    = Q_DEPTH - 5'h01;
	localparam [16:0] TICK_LAST = TICK_DIV[16:0] - 17'h00001;
	localparam [15:0] PWR_LIMIT = PWR_MS[15:0];

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function [1:0] err_class;
		input [15:0] code;
		reg   [15:0] mag;
		begin
			mag = 16'h0000 - code;
			if (mag < 16'h00C8)
				err_class = `PLQ_CLASS_CMD;
			else if (mag < 16'h012C)
				err_class = `PLQ_CLASS_EXEC;
			else if (mag < 16'h0190)
				err_class = `PLQ_CLASS_DEV;
			else
				err_class = `PLQ_CLASS_QUERY;
		end
	endfunction

	function [4:0] wrap_inc;
		input [4:0] p;
		begin
			if (p == Q_LAST)
				wrap_inc = 5'h00;
			else
				wrap_inc = p + 5'h01;
		end
	endfunction

	// ----------------------------------------
	// Millisecond tick
	// ----------------------------------------
	reg  [16:0] tick_cnt;
	wire        tick = (tick_cnt == TICK_LAST);

	always @(posedge clk)
	begin
		if (!resetn)
			tick_cnt <= 17'h00000;
		else if (tick)
			tick_cnt <= 17'h00000;
		else
			tick_cnt <= tick_cnt + 17'h00001;
	end

	// ----------------------------------------
	// Error queue
	// ----------------------------------------
	reg  [15:0] q_mem [0:DEPTH-1];
	reg  [4:0]  q_head;
	reg  [4:0]  q_tail;
	reg  [4:0]  q_count;
	reg         q_over;
	reg  [1:0]  last_class;
	wire        push = wr && (addr == `PLQ_ADDR_ERR_PUSH);
	wire        pop  = rd && (addr == `PLQ_ADDR_ERRQ) && (q_count != 5'h00);
	wire [4:0]  newest = (q_tail == 5'h00) ? Q_LAST : q_tail - 5'h01;

	assign err_indicator = (q_count != 5'h00);

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			q_head     <= 5'h00;
			q_tail     <= 5'h00;
			q_count    <= 5'h00;
			q_over     <= 1'b0;
			last_class <= `PLQ_CLASS_CMD;
		end
		else
		begin
			if (pop)
			begin
				q_head <= wrap_inc(q_head);
				q_over <= 1'b0;
			end
			if (push && !q_over)
			begin
				last_class <= err_class(wdata);
				if (q_count == Q_DEPTH && !pop)
				begin
					q_mem[newest] <= `PLQ_ERR_TOO_MANY;
					q_over        <= 1'b1;
				end
				else
				begin
					q_mem[q_tail] <= wdata;
					q_tail        <= wrap_inc(q_tail);
				end
			end
			if (push && !q_over && !(q_count == Q_DEPTH && !pop) && !pop)
				q_count <= q_count + 5'h01;
			else if (pop && !(push && !q_over))
				q_count <= q_count - 5'h01;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	reg  [9:0]  enable;
	reg         iprot_enable;
	reg  [15:0] iprot_level;
	reg  [15:0] iprot_delay;
	reg  [15:0] st_code;
	wire        cmd_wr = wr && (addr == `PLQ_ADDR_CMD);
	wire        clear  = key_clear ||
		(cmd_wr && wdata[7:0] == `PLQ_CMD_CLEAR);

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			enable       <= 10'h000;
			iprot_enable <= 1'b0;
			iprot_level  <= `PLQ_RST_IPROT_LEVEL;
			iprot_delay  <= `PLQ_RST_IPROT_DELAY;
		end
		else if (wr && !latched)
		begin
			case (addr)
			`PLQ_ADDR_ENABLE:      enable       <= wdata[9:0];
			`PLQ_ADDR_IPROT_CTRL:  iprot_enable <= wdata[0];
			`PLQ_ADDR_IPROT_LEVEL: iprot_level  <= wdata;
			`PLQ_ADDR_IPROT_DELAY: iprot_delay  <= wdata;
			default:               ;
			endcase
		end
	end

	// Protection level is compared by the analog side; kept for readback
	// ----------------------------------------
	// Fault timers
	// ----------------------------------------
	reg  [15:0] curr_ms;
	reg  [15:0] pwr_ms;
	wire        curr_trip = iprot_enable && over_current &&
		(curr_ms >= iprot_delay);
	wire        pwr_trip  = over_power && (pwr_ms >= PWR_LIMIT);

	assign power_limit = over_power;
	assign current_timing_indicator =
		iprot_enable && over_current && !curr_trip && !latched;

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			curr_ms <= 16'h0000;
			pwr_ms  <= 16'h0000;
		end
		else
		begin
			if (!iprot_enable || !over_current || clear)
				curr_ms <= 16'h0000;
			else if (tick && curr_ms != 16'hFFFF)
				curr_ms <= curr_ms + 16'h0001;
			if (!over_power)
				pwr_ms <= 16'h0000;
			else if (tick && pwr_ms != 16'hFFFF)
				pwr_ms <= pwr_ms + 16'h0001;
		end
	end

	// ----------------------------------------
	// Protection latch and status
	// ----------------------------------------
	reg  [9:0]  status;
	reg  [9:0]  event_flags;
	wire        fault = over_voltage || reversed || over_temp ||
		curr_trip || pwr_trip;
	wire [9:0]  cond;

	assign cond[`PLQ_BIT_EXVOLT] = over_voltage;
	assign cond[`PLQ_BIT_EXCURR] = curr_trip;
	assign cond[`PLQ_BIT_EXPOWR] = pwr_trip;
	assign cond[`PLQ_BIT_THERML] = over_temp;
	assign cond[`PLQ_BIT_REVPOL] = reversed;
	assign cond[`PLQ_BIT_VSUMRY] = over_voltage || reversed;
	assign cond[`PLQ_BIT_PSUMRY] = curr_trip || pwr_trip || over_temp;
	assign cond[`PLQ_BIT_CTIMER] = current_timing_indicator;
	assign cond[`PLQ_BIT_LAT] = fault;
	assign cond[`PLQ_BIT_ERR] = err_indicator;
	assign status_event = |(event_flags & enable);

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			latched     <= 1'b0;
			buzzer      <= 1'b0;
			input_on    <= 1'b0;
			status      <= 10'h000;
			event_flags <= 10'h000;
			low_range_constant_current_mode <= 1'b0;
		end
		else
		begin
			if (selftest_done && selftest_fail == 6'h00)
				low_range_constant_current_mode <= 1'b1;
			// Set wins over clear; gone conditions drop on clear
			if (clear)
				status <= cond;
			else
				status <= status | cond;
			if (rd && addr == `PLQ_ADDR_EVENT)
				event_flags <= cond & ~status;
			else
				event_flags <= event_flags | (cond & ~status);
			if (fault)
			begin
				latched  <= 1'b1;
				buzzer   <= 1'b1;
				input_on <= 1'b0;
			end
			else if (clear)
			begin
				latched <= 1'b0;
				buzzer  <= 1'b0;
			end
			else if (!latched)
			begin
				if (key_input_toggle)
					input_on <= !input_on;
				else if (cmd_wr && wdata[7:0] == `PLQ_CMD_INPUT_ON)
					input_on <= 1'b1;
				else if (cmd_wr && wdata[7:0] == `PLQ_CMD_INPUT_OFF)
					input_on <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Self-test code capture
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (!resetn)
			st_code <= `PLQ_ERR_NONE;
		else if (selftest_done)
		begin
			if (selftest_fail[0])
				st_code <= `PLQ_ST_DISPLAY;
			else if (selftest_fail[1])
				st_code <= `PLQ_ST_ADC;
			else if (selftest_fail[2])
				st_code <= `PLQ_ST_NOISY;
			else if (selftest_fail[3])
				st_code <= `PLQ_ST_KEYPAD;
			else if (selftest_fail[4])
				st_code <= `PLQ_ST_CHECKSUM;
			else if (selftest_fail[5])
				st_code <= `PLQ_ST_TEMP;
			else
				st_code <= `PLQ_ERR_NONE;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (!resetn)
			rdata <= 16'h0000;
		else if (rd)
		begin
			case (addr)
			`PLQ_ADDR_ERRQ:
				rdata <= (q_count != 5'h00) ? q_mem[q_head]
					: `PLQ_ERR_NONE;
			`PLQ_ADDR_COUNT:    rdata <= {9'h000, last_class, q_count};
			`PLQ_ADDR_STATUS:   rdata <= {6'h00, status};
			`PLQ_ADDR_ENABLE:   rdata <= {6'h00, enable};
			`PLQ_ADDR_EVENT:    rdata <= {6'h00, event_flags};
			`PLQ_ADDR_IPROT_CTRL:  rdata <= {15'h0000, iprot_enable};
			`PLQ_ADDR_IPROT_LEVEL: rdata <= iprot_level;
			`PLQ_ADDR_IPROT_DELAY: rdata <= iprot_delay;
			`PLQ_ADDR_SELFTEST: rdata <= st_code;
			default:            rdata <= 16'h0000;
			endcase
		end
	end

endmodule
